// ### hdl/fsp_defs.svh
// constants for the code-flash protection configuration block
// assumes inclusion by bare name from the package and the testbench
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH

// security word geometry and erased state
`define FSP_WORD_W        24
`define FSP_ERASED        24'hff_ffff
`define FSP_IMPL_MASK     24'h00_8fef
// field positions inside the security word
`define FSP_ALTVEC_BIT    15
`define FSP_CFG_LVL_HI    11
`define FSP_CFG_LVL_LO    9
`define FSP_CFG_WP_BIT    8
`define FSP_GEN_LVL_HI    7
`define FSP_GEN_LVL_LO    6
`define FSP_GEN_WP_BIT    5
`define FSP_BOOT_OFF_BIT  3
`define FSP_BOOT_LVL_HI   2
`define FSP_BOOT_LVL_LO   1
`define FSP_BOOT_WP_BIT   0
// boot segment limit width
`define FSP_BLIM_W        13
// register offsets (byte addresses)
`define FSP_OFF_CONFIG    12'h000
`define FSP_OFF_STATUS    12'h004
`define FSP_OFF_PDATA     12'h008
`define FSP_OFF_PCMD      12'h00c
`define FSP_OFF_BLIMIT    12'h010
// status and program command bit positions
`define FSP_ST_LOADED     0
`define FSP_ST_BUSY       1
`define FSP_ST_PDENY      2
`define FSP_ST_WDENY      3
`define FSP_PCMD_GO       0

`endif

// ### hdl/fsp_pkg.sv
// types shared by the protection configuration block
// assumes fsp_defs.svh is on the include path
package fsp_pkg;
  `include "fsp_defs.svh"

  // decoded code-flash protection level of one segment
  typedef enum logic [1:0] {
    FSP_LVL_NONE,
    FSP_LVL_STANDARD,
    FSP_LVL_ENHANCED,
    FSP_LVL_HIGH
  } fsp_level_e;

  // control sequencer states
  typedef enum logic [1:0] {
    FSP_ST_LOAD,
    FSP_ST_IDLE,
    FSP_ST_PROG
  } fsp_state_e;

  typedef logic [`FSP_WORD_W-1:0] fsp_word_t;
endpackage : fsp_pkg

// ### hdl/fsp_word_store.sv
// program-once holding register for the security word
// assumes load and clear requests come from logic on the same clock
`timescale 1ns/1ns
module fsp_word_store
  import fsp_pkg::*;
(
  input  wire logic      clk,       // system clock
  input  wire logic      resetn,    // asynchronous reset, active low
  input  wire logic      load_en,   // take a fresh image from nv memory
  input  wire fsp_word_t load_data, // image read from nv memory
  input  wire logic      clr_en,    // program: only clear bits
  input  wire fsp_word_t clr_data,  // zeros mark bits to program
  output fsp_word_t      q          // held word, registered
);
  fsp_word_t word_ff;   // stored word
  fsp_word_t nxt_word;  // next stored word

  // unimplemented bits always read as one; programming can only
  // move an implemented bit from one to zero, never back
  always_comb begin
    nxt_word = word_ff;
    if (load_en) begin
      nxt_word = load_data | ~`FSP_IMPL_MASK;
    end else if (clr_en) begin
      nxt_word = word_ff & (clr_data | ~`FSP_IMPL_MASK);
    end
  end

  // erased value means least protection until the image arrives
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      word_ff <= `FSP_ERASED;
    end else begin
      word_ff <= nxt_word;
    end
  end

  assign q = word_ff;
endmodule : fsp_word_store

// ### hdl/fsp_top.sv
// code-flash segment protection configuration with apb access
// assumes flash controller and nv memory share CLK with this block
//
// What this block does
// - config segment writable only while its bit is 1
// - general level: 11 none, 10 standard, 0x high
// - general segment writes need write-protect bit 1
// - boot disable 1 means no boot segment
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ns
module fsp_top
  import fsp_pkg::*;
#(
  parameter int ADDR_W   = 24,      // flash byte address width
  parameter int PAGE_LSB = 11,      // boot limit granule, log2 bytes
  parameter logic [23:0] CFG_BASE = 24'hff_f000 // config segment start
)(
  input  wire logic                    CLK,
  input  wire logic                    RESETN,
  // apb slave
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [11:0]             PADDR,
  input  wire logic [31:0]             PWDATA,
  output logic [31:0]                  PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  // nv configuration memory
  output logic                         NV_LOAD_REQ,
  input  wire logic                    NV_LOAD_VALID,
  input  wire fsp_word_t               NV_LOAD_DATA,
  output logic                         NV_PROG_REQ,
  output fsp_word_t                    NV_PROG_DATA,
  input  wire logic                    NV_PROG_DONE,
  input  wire logic [`FSP_BLIM_W-1:0]  BOOT_SEGMENT_LIMIT,
  // flash controller write check
  input  wire logic                    WR_CHECK,
  input  wire logic [ADDR_W-1:0]       WR_ADDR,
  output logic                         WR_DONE,
  output logic                         WR_OK,
  // decoded protection controls
  output fsp_level_e                   CONFIG_SEGMENT_PROTECT_LEVEL,
  output fsp_level_e                   GENERAL_SEGMENT_PROTECT_LEVEL,
  output fsp_level_e                   BOOT_SEGMENT_PROTECT_LEVEL,
  output logic                         BOOT_SEGMENT_PRESENT
);
  import fsp_pkg::*;

  // page index must match the boot limit width for the compare
  if (ADDR_W - PAGE_LSB != `FSP_BLIM_W) begin : g_bad_geometry
    $error("fsp_top: ADDR_W - PAGE_LSB must equal boot limit width");
  end
  if (ADDR_W > 24) begin : g_bad_addr
    $error("fsp_top: ADDR_W above 24 is not served");
  end

  // ---------------------------------------------------------------
  // held security word and its fields
  // ---------------------------------------------------------------
  fsp_word_t word;         // code_protection_config as held
  fsp_word_t prog_data_ff; // staged programming image
  logic      load_en;      // image capture strobe
  logic      clr_en;       // program completion strobe
  logic      cfg_wp_n;     // config_segment_write_protect
  logic      gen_wp_n;     // general_segment_write_protect
  logic      boot_wp_n;    // boot_segment_write_protect
  logic      boot_dis;     // boot_segment_disable

  fsp_word_store fsp_word_store_inst (
    .clk       (CLK),
    .resetn    (RESETN),
    .load_en   (load_en),
    .load_data (NV_LOAD_DATA),
    .clr_en    (clr_en),
    .clr_data  (prog_data_ff),
    .q         (word)
  );

  assign cfg_wp_n  = word[`FSP_CFG_WP_BIT];
  assign gen_wp_n  = word[`FSP_GEN_WP_BIT];
  assign boot_wp_n = word[`FSP_BOOT_WP_BIT];
  assign boot_dis  = word[`FSP_BOOT_OFF_BIT];

  // ---------------------------------------------------------------
  // level decode
  // ---------------------------------------------------------------
  // two-bit level fields share one decode
  function automatic fsp_level_e dec2(input logic [1:0] f);
    fsp_level_e l;
    l = FSP_LVL_HIGH;                        // 0x gives high
    if (f == 2'h3) begin
      l = FSP_LVL_NONE;                      // only the write protect
    end else if (f == 2'h2) begin
      l = FSP_LVL_STANDARD;
    end
    return l;
  endfunction : dec2

  // three-bit config level adds an enhanced step
  function automatic fsp_level_e dec3(input logic [2:0] f);
    fsp_level_e l;
    l = FSP_LVL_HIGH;                        // 0xx
    if (f == 3'h7) begin
      l = FSP_LVL_NONE;
    end else if (f == 3'h6) begin
      l = FSP_LVL_STANDARD;
    end else if (f[2]) begin
      l = FSP_LVL_ENHANCED;                  // 10x
    end
    return l;
  endfunction : dec3

  // decoded levels come straight from the held register bits
  always_comb begin
    CONFIG_SEGMENT_PROTECT_LEVEL  =
      dec3(word[`FSP_CFG_LVL_HI:`FSP_CFG_LVL_LO]);
    GENERAL_SEGMENT_PROTECT_LEVEL =
      dec2(word[`FSP_GEN_LVL_HI:`FSP_GEN_LVL_LO]);
    BOOT_SEGMENT_PROTECT_LEVEL    =
      dec2(word[`FSP_BOOT_LVL_HI:`FSP_BOOT_LVL_LO]);
    BOOT_SEGMENT_PRESENT          = ~boot_dis;
  end

  // ---------------------------------------------------------------
  // control sequencer: load image, then serve program commands
  // ---------------------------------------------------------------
  fsp_state_e state_ff;      // sequencer state
  fsp_state_e nxt_state;
  fsp_word_t  nxt_prog_data;
  logic       pdeny_ff;      // sticky: program refused
  logic       nxt_pdeny;
  logic       wdeny_ff;      // sticky: flash write refused
  logic       nxt_wdeny;
  logic       wr_en;         // apb write at access edge
  logic       go_cmd;        // program command written
  logic       st_clr_p;      // w1c of program-refused flag
  logic       st_clr_w;      // w1c of write-refused flag
  logic       wr_done_ff;    // write check answer strobe
  logic       nxt_wr_done;
  logic       wr_ok_ff;      // write check verdict
  logic       nxt_wr_ok;

  assign wr_en    = PSEL & PENABLE & PWRITE;
  assign go_cmd   = wr_en & (PADDR == `FSP_OFF_PCMD) &
                    PWDATA[`FSP_PCMD_GO];
  assign st_clr_p = wr_en & (PADDR == `FSP_OFF_STATUS) &
                    PWDATA[`FSP_ST_PDENY];
  assign st_clr_w = wr_en & (PADDR == `FSP_OFF_STATUS) &
                    PWDATA[`FSP_ST_WDENY];

  // sequencer next state; refusals are sticky and a new refusal in
  // the same cycle as its clear survives the clear
  always_comb begin
    nxt_state     = state_ff;
    nxt_prog_data = prog_data_ff;
    nxt_pdeny     = pdeny_ff & ~st_clr_p;
    load_en       = 1'b0;
    clr_en        = 1'b0;
    if (wr_en && (PADDR == `FSP_OFF_PDATA) && (state_ff != FSP_ST_PROG)) begin
      nxt_prog_data = PWDATA[`FSP_WORD_W-1:0];
    end
    unique case (state_ff)
      FSP_ST_LOAD: begin
        if (NV_LOAD_VALID) begin
          load_en   = 1'b1;
          nxt_state = FSP_ST_IDLE;
        end
      end
      FSP_ST_IDLE: begin
        if (go_cmd) begin
          if (cfg_wp_n) begin
            nxt_state = FSP_ST_PROG;
          end else begin
            nxt_pdeny = 1'b1;
          end
        end
      end
      FSP_ST_PROG: begin
        if (NV_PROG_DONE) begin
          clr_en    = 1'b1;
          nxt_state = FSP_ST_IDLE;
        end
      end
    endcase
    // a command while loading or busy is refused as well
    if (go_cmd && (state_ff != FSP_ST_IDLE)) begin
      nxt_pdeny = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // write check: one answer per request, one cycle later
  // ---------------------------------------------------------------
  logic [`FSP_BLIM_W-1:0]  page;   // boot-limit granule of address
  logic                    in_cfg; // address in config segment
  logic                    in_boot;// address in boot segment

  assign page    = WR_ADDR[ADDR_W-1:PAGE_LSB];
  assign in_cfg  = 24'(WR_ADDR) >= CFG_BASE;
  assign in_boot = ~boot_dis & (page < BOOT_SEGMENT_LIMIT);

  // nothing is writable until the image has been loaded, so a
  // controller that starts early fails closed
  always_comb begin
    nxt_wr_done = WR_CHECK;
    nxt_wr_ok   = 1'b0;
    nxt_wdeny   = wdeny_ff & ~st_clr_w;
    if (WR_CHECK) begin
      if (state_ff == FSP_ST_LOAD) begin
        nxt_wr_ok = 1'b0;
      end else if (in_cfg) begin
        nxt_wr_ok = cfg_wp_n;
      end else if (in_boot) begin
        nxt_wr_ok = boot_wp_n;
      end else begin
        nxt_wr_ok = gen_wp_n;
      end
      if (!nxt_wr_ok) begin
        nxt_wdeny = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // apb read path: data registered in the setup cycle
  // ---------------------------------------------------------------
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        mapped;     // address hits a register

  always_comb begin
    mapped     = 1'b1;
    nxt_prdata = prdata_ff;
    unique case (PADDR)
      `FSP_OFF_CONFIG: nxt_prdata = {8'h00, word};
      `FSP_OFF_STATUS: nxt_prdata = {28'h000_0000, wdeny_ff, pdeny_ff,
                                      state_ff == FSP_ST_PROG,
                                      state_ff != FSP_ST_LOAD};
      `FSP_OFF_PDATA:  nxt_prdata = {8'h00, prog_data_ff};
      `FSP_OFF_PCMD:   nxt_prdata = 32'h0000_0000;
      `FSP_OFF_BLIMIT: nxt_prdata = {19'h0_0000, BOOT_SEGMENT_LIMIT};
      default: begin
        mapped     = 1'b0;
        nxt_prdata = 32'h0000_0000;
      end
    endcase
    if (!(PSEL && !PENABLE)) begin
      nxt_prdata = prdata_ff;
    end
  end

  // zero wait states; unmapped addresses answer with an error and
  // writes to the read-only word are silently dropped
  assign PREADY  = PSEL & PENABLE;
  assign PSLVERR = PSEL & PENABLE & ~mapped;
  assign PRDATA  = prdata_ff;

  // ---------------------------------------------------------------
  // register all state
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_ff     <= FSP_ST_LOAD;
      prog_data_ff <= `FSP_ERASED;
      pdeny_ff     <= 1'b0;
      wdeny_ff     <= 1'b0;
      wr_done_ff   <= 1'b0;
      wr_ok_ff     <= 1'b0;
      prdata_ff    <= 32'h0000_0000;
    end else begin
      state_ff     <= nxt_state;
      prog_data_ff <= nxt_prog_data;
      pdeny_ff     <= nxt_pdeny;
      wdeny_ff     <= nxt_wdeny;
      wr_done_ff   <= nxt_wr_done;
      wr_ok_ff     <= nxt_wr_ok;
      prdata_ff    <= nxt_prdata;
    end
  end

  // nv memory handshake levels follow the sequencer state
  assign NV_LOAD_REQ  = (state_ff == FSP_ST_LOAD);
  assign NV_PROG_REQ  = (state_ff == FSP_ST_PROG);
  assign NV_PROG_DATA = prog_data_ff & word; // only clears bits
  assign WR_DONE      = wr_done_ff;
  assign WR_OK        = wr_ok_ff;
endmodule : fsp_top

// ### dv/fsp_checker.sv
// port assertions for the protection configuration block
// assumes one clock domain, reset active low and asynchronous
`timescale 1ns/1ns
module fsp_checker
  import fsp_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RESETN,
  input wire logic       NV_LOAD_REQ,
  input wire logic       NV_LOAD_VALID,
  input wire logic       NV_PROG_REQ,
  input wire logic       NV_PROG_DONE,
  input wire logic       WR_CHECK,
  input wire logic       WR_DONE,
  input wire logic       WR_OK,
  input wire fsp_level_e CONFIG_SEGMENT_PROTECT_LEVEL,
  input wire fsp_level_e GENERAL_SEGMENT_PROTECT_LEVEL,
  input wire fsp_level_e BOOT_SEGMENT_PROTECT_LEVEL,
  input wire logic       BOOT_SEGMENT_PRESENT
);
  // every property shares the system clock and reset
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  a_check_answer: assert property (WR_CHECK |=> WR_DONE)
    else $error("write check not answered");
  a_done_cause: assert property (WR_DONE |-> $past(WR_CHECK))
    else $error("write check answer without query");
  a_ok_with_done: assert property (WR_OK |-> WR_DONE)
    else $error("write verdict outside answer");
  a_unloaded_refused: assert property (
    WR_CHECK && NV_LOAD_REQ |=> !WR_OK)
    else $error("write allowed before image load");
  a_gen_two_bit: assert property (
    GENERAL_SEGMENT_PROTECT_LEVEL != FSP_LVL_ENHANCED)
    else $error("general level has no enhanced code");
  a_boot_two_bit: assert property (
    BOOT_SEGMENT_PROTECT_LEVEL != FSP_LVL_ENHANCED)
    else $error("boot level has no enhanced code");
  // controls move only after an image load or a programming cycle
  a_levels_held: assert property (
    !$past(NV_LOAD_VALID) && !$past(NV_PROG_DONE) |->
    $stable(CONFIG_SEGMENT_PROTECT_LEVEL) &&
    $stable(GENERAL_SEGMENT_PROTECT_LEVEL) &&
    $stable(BOOT_SEGMENT_PROTECT_LEVEL) && $stable(BOOT_SEGMENT_PRESENT))
    else $error("protection controls changed on their own");
  a_high_sticks: assert property (
    GENERAL_SEGMENT_PROTECT_LEVEL == FSP_LVL_HIGH && !NV_LOAD_REQ |=>
    GENERAL_SEGMENT_PROTECT_LEVEL == FSP_LVL_HIGH)
    else $error("program-once level returned to lower security");
  a_prog_ends: assert property (
    NV_PROG_REQ && NV_PROG_DONE |=> !NV_PROG_REQ)
    else $error("programming request outlived done");
  a_load_once: assert property (
    NV_LOAD_REQ && NV_LOAD_VALID |=> !NV_LOAD_REQ [*3])
    else $error("image load request returned");

  c_ok: cover property (WR_DONE && WR_OK);
  c_refused: cover property (WR_DONE && !WR_OK);
  c_prog: cover property (NV_PROG_REQ && NV_PROG_DONE);
endmodule : fsp_checker

bind fsp_top fsp_checker fsp_checker_inst (
  .CLK(CLK), .RESETN(RESETN), .NV_LOAD_REQ(NV_LOAD_REQ),
  .NV_LOAD_VALID(NV_LOAD_VALID), .NV_PROG_REQ(NV_PROG_REQ),
  .NV_PROG_DONE(NV_PROG_DONE), .WR_CHECK(WR_CHECK), .WR_DONE(WR_DONE),
  .WR_OK(WR_OK),
  .CONFIG_SEGMENT_PROTECT_LEVEL(CONFIG_SEGMENT_PROTECT_LEVEL),
  .GENERAL_SEGMENT_PROTECT_LEVEL(GENERAL_SEGMENT_PROTECT_LEVEL),
  .BOOT_SEGMENT_PROTECT_LEVEL(BOOT_SEGMENT_PROTECT_LEVEL),
  .BOOT_SEGMENT_PRESENT(BOOT_SEGMENT_PRESENT));

// ### dv/testbench.sv
// self-checking bench: apb and write-check tasks over four images
// assumes the nv memory is modelled by the bench's own stimulus
`timescale 1ns/1ns
`include "fsp_defs.svh"
module testbench;
  import fsp_pkg::*;
  localparam fsp_word_t ONES = ~`FSP_IMPL_MASK; // unimplemented read 1
  localparam int        LIMIT = 5000;           // far above run length
  logic        CLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic        NV_LOAD_REQ, NV_LOAD_VALID, NV_PROG_REQ, NV_PROG_DONE;
  fsp_word_t   NV_LOAD_DATA, NV_PROG_DATA, WR_ADDR, img, word;
  logic [12:0] BOOT_SEGMENT_LIMIT;
  logic        WR_CHECK, WR_DONE, WR_OK, BOOT_SEGMENT_PRESENT, err;
  fsp_level_e  CONFIG_SEGMENT_PROTECT_LEVEL, GENERAL_SEGMENT_PROTECT_LEVEL;
  fsp_level_e  BOOT_SEGMENT_PROTECT_LEVEL;
  int          errors, comparisons, cycles;
  // images chosen to hit every level code and write-protect mix
  fsp_word_t   imgs [4] = '{24'hff_ffff, 24'hff_fdb4, 24'hff_f879,
                            24'hef_f70b};

  fsp_top fsp_top_inst (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .NV_LOAD_REQ(NV_LOAD_REQ), .NV_LOAD_VALID(NV_LOAD_VALID),
    .NV_LOAD_DATA(NV_LOAD_DATA), .NV_PROG_REQ(NV_PROG_REQ),
    .NV_PROG_DATA(NV_PROG_DATA), .NV_PROG_DONE(NV_PROG_DONE),
    .BOOT_SEGMENT_LIMIT(BOOT_SEGMENT_LIMIT), .WR_CHECK(WR_CHECK),
    .WR_ADDR(WR_ADDR), .WR_DONE(WR_DONE), .WR_OK(WR_OK),
    .CONFIG_SEGMENT_PROTECT_LEVEL(CONFIG_SEGMENT_PROTECT_LEVEL),
    .GENERAL_SEGMENT_PROTECT_LEVEL(GENERAL_SEGMENT_PROTECT_LEVEL),
    .BOOT_SEGMENT_PROTECT_LEVEL(BOOT_SEGMENT_PROTECT_LEVEL),
    .BOOT_SEGMENT_PRESENT(BOOT_SEGMENT_PRESENT));

  // 10 MHz clock
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end

  // hang guard
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; waits for pready, takes data at that edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // pready ends this wait; only the hang guard stops one that never ends
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  // write permission query, answer one cycle after it is taken
  task automatic wr(input fsp_word_t a, input logic ok);
    @(posedge CLK);
    WR_CHECK <= 1'b1;
    WR_ADDR  <= a;
    @(posedge CLK);
    WR_CHECK <= 1'b0;
    @(posedge CLK);
    check({31'h0, WR_DONE}, 32'h1);
    check({31'h0, WR_OK}, {31'h0, ok});
  endtask : wr

  function automatic fsp_level_e lvl(input logic [2:0] b);
    if (b == 3'b111) return FSP_LVL_NONE;
    if (b == 3'b110) return FSP_LVL_STANDARD;
    return b[2] ? FSP_LVL_ENHANCED : FSP_LVL_HIGH;
  endfunction : lvl

  // decoded controls and the readable word against an expected word
  task automatic levels(input fsp_word_t w);
    check({30'h0, CONFIG_SEGMENT_PROTECT_LEVEL},
          {30'h0, lvl(w[11:9])});
    check({30'h0, GENERAL_SEGMENT_PROTECT_LEVEL},
          {30'h0, lvl({w[7], w[7:6]})});
    check({30'h0, BOOT_SEGMENT_PROTECT_LEVEL},
          {30'h0, lvl({w[2], w[2:1]})});
    check({31'h0, BOOT_SEGMENT_PRESENT}, {31'h0, ~w[3]});
    apb(1'b0, `FSP_OFF_CONFIG, 32'h0);
    check(rd, {8'h0, w | ONES});
  endtask : levels

  initial begin
    RESETN = 1'b0;
    {PSEL, PENABLE, PWRITE, NV_LOAD_VALID, NV_PROG_DONE, WR_CHECK} = '0;
    {PADDR, PWDATA, NV_LOAD_DATA, WR_ADDR} = '0;
    BOOT_SEGMENT_LIMIT = 13'h0010;
    {errors, comparisons, cycles} = '0;
    for (int i = 0; i < 4; i++) begin
      img = imgs[i];
      RESETN <= 1'b0;
      repeat (5) @(posedge CLK);
      RESETN <= 1'b1;
      wr(24'hff_f800, 1'b0);
      check({31'h0, NV_LOAD_REQ}, 32'h1);
      levels(24'hff_ffff);
      @(posedge CLK);
      NV_LOAD_VALID <= 1'b1;
      NV_LOAD_DATA  <= img;
      @(posedge CLK);
      NV_LOAD_VALID <= 1'b0;
      NV_LOAD_DATA  <= ~img;
      word = img | ONES;
      // config word is read-only, status refusal flag cleared first
      apb(1'b1, `FSP_OFF_CONFIG, 32'h0);
      apb(1'b1, `FSP_OFF_STATUS, 32'h0000_0008);
      check({31'h0, NV_LOAD_REQ}, 32'h0);
      levels(word);
      wr(24'hff_f800, img[8]);
      wr(24'h00_1000, img[3] ? img[5] : img[0]);
      wr(24'h10_0000, img[5]);
      apb(1'b0, `FSP_OFF_STATUS, 32'h0);
      check({30'h0, rd[1:0]}, 32'h1);
      check({31'h0, rd[3]},
            {31'h0, ~(img[8] & img[5] & (img[3] | img[0]))});
      if (i == 0) begin
        apb(1'b0, 12'h020, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
      end
      // stage clears of general level and write enable, then program
      apb(1'b1, `FSP_OFF_PDATA, 32'h00ff_ff5f);
      apb(1'b1, `FSP_OFF_PCMD, 32'h0000_0001);
      for (int n = 0; n < 5 && NV_PROG_REQ !== 1'b1; n++) @(posedge CLK);
      check({31'h0, NV_PROG_REQ}, {31'h0, img[8]});
      if (img[8]) begin
        check({8'h0, NV_PROG_DATA}, {8'h0, word & 24'hff_ff5f});
        NV_PROG_DONE <= 1'b1;
        @(posedge CLK);
        NV_PROG_DONE <= 1'b0;
        word = word & 24'hff_ff5f;
        @(posedge CLK);
        levels(word);
        wr(24'h10_0000, 1'b0);
      end else begin
        apb(1'b0, `FSP_OFF_STATUS, 32'h0);
        check({31'h0, rd[2]}, 32'h1);
      end
    end
    complete_run();
  end
endmodule : testbench
